// >>> hdl/adcsq_buf2.sv
`default_nettype none
module adcsq_buf2 #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} adcsq_buf_s_t;
	adcsq_buf_s_t s_q, s_d;
	logic push, pop;
	assign in_ready = (s_q.cnt != 2'h2);
	assign out_valid = (s_q.cnt != 2'h0);
	assign out_data = s_q.mem[s_q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = ~s_q.wp;
		end
		if (pop) begin
			s_d.rp = ~s_q.rp;
		end
		s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	a_buf_bound: assert property (@(posedge clk) disable iff (!rstn) s_q.cnt != 2'h3)
		else $error("buffer count out of range");
endmodule
`default_nettype wire

// >>> hdl/adcsq_ctrl.sv
`default_nettype none
// How it works
// - Seven inputs: six external, one die temperature
// - External voltage inputs differential or single-ended
// - Continuous loop or one burst then shutdown
// - Diode measured at three bias currents, cancelled
// - Temperature forces internal reference, low range
// - Temperature step is one eighth degree
// - Voltage reference selectable; two trimmed ranges
// - Voltage conversion takes 34 converter cycles
// - Converter clock divided down, at least 16
// - Acquisition extension lengthens the sample phase
// - Eight per-slot configuration words with options
// - Sixteen 13-bit results in circular store
// - Flag set after programmed sample count
// - Flag held until software clear or start
// - Stop mode aborts, clears go, powers down
// - After stop, idle until go written
// - Wait 20 converter cycles before acquiring
module adcsq_ctrl
	import adcsq_pkg::*;
#(
	parameter int SEQ_SLOTS = adcsq_pkg::NUM_SLOT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Software control
	input wire logic go_write,
	input wire logic stop_mode,
	input wire logic cont_mode,
	input wire logic [adcsq_pkg::SLOT_W:0] seq_len,
	input wire logic [SEQ_SLOTS*adcsq_pkg::CFG_W-1:0] slot_cfg,
	input wire logic [adcsq_pkg::DIV_W-1:0] clk_ratio,
	input wire logic [adcsq_pkg::DIV_W-1:0] acq_ext,
	input wire logic fs_high,
	input wire logic [adcsq_pkg::TRIM_W-1:0] low_range_gain_trim,
	input wire logic [adcsq_pkg::TRIM_W-1:0] high_range_gain_trim,
	input wire logic [adcsq_pkg::BUF_IDX_W:0] ready_count,
	input wire logic flag_clear,
	// Status
	output logic conversion_go_bit,
	output logic samples_ready_flag,
	output logic busy,
	output logic powered_down,
	// Analog front end
	output logic converter_clock,
	output logic [adcsq_pkg::CH_W-1:0] mux_sel,
	output logic diff_sel,
	output logic diode_bias_on,
	output logic [adcsq_pkg::BIAS_W-1:0] diode_bias,
	output logic ref_internal,
	output logic fs_low,
	output logic [adcsq_pkg::TRIM_W-1:0] gain_trim,
	output logic sample,
	input wire logic [adcsq_pkg::CODE_W-1:0] adc_code,
	// Result stream
	output logic res_valid,
	input wire logic res_ready,
	output logic [adcsq_pkg::BUF_W-1:0] res_data,
	output logic [adcsq_pkg::CH_W-1:0] res_chan,
	// Result store read
	input wire logic [adcsq_pkg::BUF_IDX_W-1:0] rd_idx,
	output logic [adcsq_pkg::BUF_W-1:0] rd_data,
	output logic [adcsq_pkg::BUF_IDX_W-1:0] wr_ptr
);
	import adcsq_pkg::*;
	localparam int PW = CH_W + BUF_W;
	typedef struct packed {
		adcsq_state_t st;
		logic [DIV_W-1:0] div_cnt;
		logic [CNT_W-1:0] cnt;
		logic [SLOT_W-1:0] slot;
		logic [BIAS_W-1:0] bias;
		logic [CODE_W-1:0] v0;
		logic [CODE_W-1:0] v1;
		logic [BUF_W-1:0] res;
		logic go;
		logic flag;
		logic [BUF_IDX_W:0] nsamp;
		logic [BUF_IDX_W-1:0] wp;
		logic [NUM_BUF-1:0][BUF_W-1:0] mem;
		logic [BUF_W-1:0] rd;
	} adcsq_ctrl_s_t;
	adcsq_ctrl_s_t s_q, s_d;
	logic [CFG_W-1:0] cfg;
	logic [CH_W-1:0] chan;
	logic is_die, is_temp, ext_temp, tick, in_valid, in_ready, store, start, last_slot;
	logic [DIV_W-1:0] div_n;
	logic [CNT_W-1:0] acq_len;
	logic [PW-1:0] buf_out;
	logic signed [BUF_W:0] d1, d2, tcalc;
	localparam logic [DIV_W-1:0] DIV_MIN_V = DIV_W'(DIV_MIN);
	localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(START_WAIT - 1);
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - ACQ_CYC - 1);
	localparam logic [BIAS_W-1:0] BIAS_LAST = BIAS_W'(TEMP_PTS - 1);
	assign cfg = slot_cfg[s_q.slot*CFG_W +: CFG_W];
	assign is_die = (cfg[CFG_CH_LSB +: CH_W] >= CH_W'(DIE_CH));
	assign chan = is_die ? CH_W'(DIE_CH) : cfg[CFG_CH_LSB +: CH_W];
	assign ext_temp = cfg[CFG_TEMP] && !is_die;
	assign is_temp = ext_temp || is_die;
	assign div_n = (clk_ratio < DIV_MIN_V) ? DIV_MIN_V : clk_ratio;
	assign tick = (s_q.st != ST_OFF) && (s_q.div_cnt == div_n - 8'h01);
	assign acq_len = CNT_W'(ACQ_CYC) + ((cfg[CFG_ACQ_EXT] && !is_temp) ? {1'b0, acq_ext} : 9'h000);
	assign last_slot = ({1'b0, s_q.slot} == seq_len - 4'h1) || (s_q.slot == SLOT_W'(SEQ_SLOTS - 1));
	assign in_valid = (s_q.st == ST_PUSH);
	assign start = (s_q.st == ST_OFF) && go_write && !stop_mode;
	assign store = res_valid && res_ready;
	// Three-point cancellation: the series-resistance drop grows linearly with bias step
	assign d1 = (BUF_W + 1)'(s_q.v1) - (BUF_W + 1)'(s_q.v0);
	assign d2 = (BUF_W + 1)'(adc_code) - (BUF_W + 1)'(s_q.v1);
	assign tcalc = (d1 <<< 1) - d2;
	always_comb begin
		s_d = s_q;
		s_d.div_cnt = (s_q.st == ST_OFF || tick) ? 8'h00 : s_q.div_cnt + 8'h01;
		unique case (s_q.st)
			ST_OFF: begin
				if (start) begin
					s_d.go = 1'b1;
					s_d.st = ST_WAIT;
					s_d.cnt = '0;
					s_d.slot = '0;
					s_d.bias = '0;
					s_d.nsamp = '0;
				end
			end
			ST_WAIT: begin
				if (tick) begin
					s_d.cnt = s_q.cnt + 9'h001;
					if (s_q.cnt == WAIT_LAST) begin
						s_d.st = ST_ACQ;
						s_d.cnt = '0;
					end
				end
			end
			ST_ACQ: begin
				if (tick) begin
					s_d.cnt = s_q.cnt + 9'h001;
					if (s_q.cnt == acq_len - 9'h001) begin
						s_d.st = ST_CONV;
						s_d.cnt = '0;
					end
				end
			end
			ST_CONV: begin
				if (tick) begin
					s_d.cnt = s_q.cnt + 9'h001;
					if (s_q.cnt == CONV_LAST) begin
						s_d.cnt = '0;
						if (ext_temp && s_q.bias != BIAS_LAST) begin
							if (s_q.bias == '0) begin
								s_d.v0 = adc_code;
							end else begin
								s_d.v1 = adc_code;
							end
							s_d.bias = s_q.bias + 2'h1;
							s_d.st = ST_ACQ;
						end else begin
							s_d.st = ST_PUSH;
							if (ext_temp) begin
								s_d.res = tcalc[BUF_W-1:0];
							end else if (is_die) begin
								s_d.res = {1'b0, adc_code};
							end else if (cfg[CFG_ALIGN_LEFT]) begin
								s_d.res = {adc_code, 1'b0};
							end else if (cfg[CFG_DIFF]) begin
								s_d.res = {adc_code[CODE_W-1], adc_code};
							end else begin
								s_d.res = {1'b0, adc_code};
							end
						end
					end
				end
			end
			ST_PUSH: begin
				if (in_ready) begin
					s_d.bias = '0;
					s_d.st = ST_ACQ;
					s_d.slot = s_q.slot + 3'h1;
					if (last_slot) begin
						s_d.slot = '0;
						if (!cont_mode) begin
							s_d.go = 1'b0;
							s_d.st = ST_OFF;
						end
					end
				end
			end
		endcase
		if (stop_mode) begin
			s_d.st = ST_OFF;
			s_d.go = 1'b0;
			s_d.cnt = '0;
		end
		// Clear first, so a sample landing in the same cycle still raises the flag
		if (flag_clear || start) begin
			s_d.flag = 1'b0;
		end
		if (store) begin
			s_d.mem[s_q.wp] = buf_out[BUF_W-1:0];
			s_d.wp = s_q.wp + 4'h1;
			s_d.nsamp = (start ? 5'h00 : s_q.nsamp) + 5'h01;
			if ((start ? 5'h00 : s_q.nsamp) + 5'h01 >= ready_count) begin
				s_d.flag = 1'b1;
				s_d.nsamp = '0;
			end
		end
		s_d.rd = s_q.mem[rd_idx];
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	adcsq_buf2 #(
		.W(PW)
	) u_buf (
		.clk(clk),
		.rstn(rstn),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data({chan, s_q.res}),
		.out_valid(res_valid),
		.out_ready(res_ready),
		.out_data(buf_out)
	);
	assign res_data = buf_out[BUF_W-1:0];
	assign res_chan = buf_out[PW-1 -: CH_W];
	assign rd_data = s_q.rd;
	assign wr_ptr = s_q.wp;
	assign conversion_go_bit = s_q.go;
	assign samples_ready_flag = s_q.flag;
	assign busy = (s_q.st != ST_OFF);
	assign powered_down = (s_q.st == ST_OFF);
	assign converter_clock = tick;
	assign mux_sel = chan;
	assign diff_sel = cfg[CFG_DIFF] && !is_temp;
	assign diode_bias_on = busy && ext_temp;
	assign diode_bias = s_q.bias;
	assign ref_internal = is_temp || !cfg[CFG_REF_EXT];
	assign fs_low = is_temp || !fs_high;
	assign gain_trim = fs_low ? low_range_gain_trim : high_range_gain_trim;
	assign sample = (s_q.st == ST_ACQ);
	sequence s_go;
		s_q.st == ST_OFF && go_write && !stop_mode;
	endsequence
	sequence s_armed;
		s_q.st == ST_WAIT && s_q.cnt == '0 && s_q.go;
	endsequence
	property p_go;
		@(posedge clk) disable iff (!rstn) s_go |=> s_armed;
	endproperty
	a_go_arms_wait: assert property (p_go)
		else $error("go write did not arm the start wait");
	a_idle_no_go: assert property (@(posedge clk) disable iff (!rstn)
		s_q.st == ST_OFF && !go_write |=> s_q.st == ST_OFF)
		else $error("converter left idle without go");
	a_stop_aborts: assert property (@(posedge clk) disable iff (!rstn)
		stop_mode |=> s_q.st == ST_OFF && !conversion_go_bit && powered_down)
		else $error("stop mode did not abort");
	a_mux_range: assert property (@(posedge clk) disable iff (!rstn)
		mux_sel < CH_W'(NUM_CH))
		else $error("mux selection out of range");
	a_temp_ref: assert property (@(posedge clk) disable iff (!rstn)
		busy && is_temp |-> ref_internal && fs_low && !diff_sel)
		else $error("temperature conversion without internal low range");
	a_tick_spacing: assert property (@(posedge clk) disable iff (!rstn)
		tick |=> !tick [*8])
		else $error("converter clock faster than minimum divide");
	a_wait_len: assert property (@(posedge clk) disable iff (!rstn)
		s_q.st == ST_WAIT && !stop_mode && !(tick && s_q.cnt == WAIT_LAST) |=> s_q.st == ST_WAIT)
		else $error("start wait ended early");
	a_conv_len: assert property (@(posedge clk) disable iff (!rstn)
		s_q.st == ST_CONV && !stop_mode && !(tick && s_q.cnt == CONV_LAST) |=> s_q.st == ST_CONV)
		else $error("conversion phase ended early");
	a_burst_done: assert property (@(posedge clk) disable iff (!rstn)
		s_q.st == ST_PUSH && in_ready && last_slot && !cont_mode |=> !conversion_go_bit && powered_down)
		else $error("single burst did not clear go");
	a_flag_hold: assert property (@(posedge clk) disable iff (!rstn)
		samples_ready_flag && !flag_clear && !start |=> samples_ready_flag)
		else $error("ready flag dropped without clear");
	a_flag_start_clr: assert property (@(posedge clk) disable iff (!rstn)
		start && !store |=> !samples_ready_flag)
		else $error("start did not clear ready flag");
	a_store_wrap: assert property (@(posedge clk) disable iff (!rstn)
		store |=> wr_ptr == $past(wr_ptr) + 4'h1)
		else $error("store pointer did not advance");
	a_push_stall: assert property (@(posedge clk) disable iff (!rstn)
		s_q.st == ST_PUSH && !in_ready && !stop_mode |=> s_q.st == ST_PUSH && $stable(s_q.res))
		else $error("result dropped while buffer full");
	a_loop_restart: assert property (@(posedge clk) disable iff (!rstn)
		s_q.st == ST_PUSH && in_ready && last_slot && cont_mode && !stop_mode |=> s_q.st == ST_ACQ && s_q.slot == '0)
		else $error("continuous loop did not restart at slot zero");
	a_flag_set: assert property (@(posedge clk) disable iff (!rstn)
		store && !start && s_q.nsamp + 5'h01 >= ready_count |=> samples_ready_flag)
		else $error("ready flag not set at sample count");
	a_bias_range: assert property (@(posedge clk) disable iff (!rstn)
		busy |-> s_q.bias <= BIAS_LAST)
		else $error("diode bias step out of range");
endmodule
`default_nettype wire

// >>> hdl/adcsq_pkg.sv
`default_nettype none
package adcsq_pkg;
	// Multiplexer: six external inputs plus the die-temperature input
	localparam int NUM_CH = 7;
	localparam int DIE_CH = 6;
	localparam int CH_W = 3;
	localparam int NUM_SLOT = 8;
	localparam int SLOT_W = 3;
	localparam int CODE_W = 12;
	localparam int BUF_W = 13;
	localparam int NUM_BUF = 16;
	localparam int BUF_IDX_W = 4;
	localparam int CNT_W = 9;
	localparam int DIV_W = 8;
	localparam int TRIM_W = 8;
	localparam int BIAS_W = 2;
	// Slot configuration word layout
	localparam int CFG_W = 8;
	localparam int CFG_CH_LSB = 0;
	localparam int CFG_DIFF = 3;
	localparam int CFG_ALIGN_LEFT = 4;
	localparam int CFG_ACQ_EXT = 5;
	localparam int CFG_REF_EXT = 6;
	localparam int CFG_TEMP = 7;
	// Timing in converter clock cycles; RATE_DIV and DIV_MIN in system clocks
	localparam int CONV_CYC = 34;
	localparam int ACQ_CYC = 4;
	localparam int START_WAIT = 20;
	localparam int TEMP_PTS = 3;
	localparam int RATE_DIV = 544;
	localparam int DIV_MIN = RATE_DIV / CONV_CYC;
	typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_ACQ, ST_CONV, ST_PUSH} adcsq_state_t;
endpackage
`default_nettype wire

// >>> tb/adcsq_afe_model.sv
`default_nettype none
module adcsq_afe_model (
	// Clock
	input wire logic clk,
	// Converter control
	input wire logic busy,
	input wire logic sample,
	input wire logic [adcsq_pkg::CH_W-1:0] mux_sel,
	input wire logic [adcsq_pkg::BIAS_W-1:0] diode_bias,
	// Conversion result
	output logic [adcsq_pkg::CODE_W-1:0] adc_code
);
	timeunit 1ns;
	timeprecision 1ns;
	import adcsq_pkg::*;
	logic [CODE_W-1:0] junk_q = 12'hA5C;
	// While idle or sampling the code wanders, so a stale capture cannot match
	always @(posedge clk) begin
		junk_q <= junk_q + 12'h3B1;
	end
	// Diode voltage rises linearly with the bias step, so the cancelled result is one step
	assign adc_code = (busy && !sample) ? {mux_sel, diode_bias, 7'h15} : junk_q;
endmodule
`default_nettype wire

// >>> tb/tb_adcsq_ctrl.sv
`default_nettype none
module tb_adcsq_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import adcsq_pkg::*;
	// Stimulus
	logic clk = 1'b0, rstn = 1'b0, go_write = 1'b0, stop_mode = 1'b0, cont_mode = 1'b0, fs_high = 1'b0;
	logic flag_clear = 1'b0, res_ready = 1'b1;
	logic [SLOT_W:0] seq_len = 4'h3;
	logic [NUM_SLOT*CFG_W-1:0] slot_cfg = '0;
	logic [DIV_W-1:0] clk_ratio = 8'h10, acq_ext = 8'h00;
	logic [TRIM_W-1:0] low_range_gain_trim = 8'h00, high_range_gain_trim = 8'h00;
	logic [BUF_IDX_W:0] ready_count = 5'h02;
	logic [BUF_IDX_W-1:0] rd_idx = 4'h0;
	// Observed
	logic conversion_go_bit, samples_ready_flag, busy, powered_down, converter_clock, diff_sel, diode_bias_on;
	logic ref_internal, fs_low, sample, res_valid;
	logic [CH_W-1:0] mux_sel, res_chan;
	logic [BIAS_W-1:0] diode_bias;
	logic [TRIM_W-1:0] gain_trim;
	logic [CODE_W-1:0] adc_code;
	logic [BUF_W-1:0] res_data, rd_data;
	logic [BUF_IDX_W-1:0] wr_ptr;
	// Bench state
	int n_fail = 0, compares = 0, n_take = 0, n_run = 0, np = 0;
	logic [15:0] sd = 16'hF5F3;
	logic sp = 1'b0, gp = 1'b0;
	logic [15:0] eq[$];
	logic [16:0] qf[$], ef[$];
	int qp[$], ep[$];
	logic [BUF_W-1:0] m[NUM_BUF];

	adcsq_ctrl adcsq_ctrl_i (.clk, .rstn, .go_write, .stop_mode, .cont_mode, .seq_len, .slot_cfg, .clk_ratio,
		.acq_ext, .fs_high, .low_range_gain_trim, .high_range_gain_trim, .ready_count, .flag_clear,
		.conversion_go_bit, .samples_ready_flag, .busy, .powered_down, .converter_clock, .mux_sel, .diff_sel,
		.diode_bias_on, .diode_bias, .ref_internal, .fs_low, .gain_trim, .sample, .adc_code, .res_valid,
		.res_ready, .res_data, .res_chan, .rd_idx, .rd_data, .wr_ptr);
	adcsq_afe_model adcsq_afe_model_i (.clk, .busy, .sample, .mux_sel, .diode_bias, .adc_code);

	always #50 clk = ~clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	function automatic logic [15:0] rnd();
		sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
		return sd;
	endfunction

	function automatic logic [2:0] chm(input logic [7:0] c);
		return (c[2:0] == 3'h7) ? 3'h6 : c[2:0];
	endfunction

	function automatic logic [12:0] exp_res(input logic [7:0] c);
		if (c[7]) return 13'h0080;
		if (c[4]) return {chm(c), 2'h0, 7'h15, 1'b0};
		return {1'b0, chm(c), 2'h0, 7'h15};
	endfunction

	function automatic logic [16:0] exp_fe(input logic [7:0] c, input logic [1:0] j);
		logic lo;
		lo = c[7] | ~fs_high;
		return {c[7], j, chm(c), c[3] & ~c[7], c[7] | ~c[6], lo, lo ? low_range_gain_trim : high_range_gain_trim};
	endfunction

	// Queue what one slot should produce: result, front-end setting and pulse counts
	task automatic add_slot(input logic [7:0] c);
		int j;
		eq.push_back({chm(c), exp_res(c)});
		for (j = 0; j < (c[7] ? TEMP_PTS : 1); j++) begin
			ef.push_back(exp_fe(c, j[1:0]));
			ep.push_back(ACQ_CYC + ((c[5] && !c[7]) ? int'(acq_ext) : 0));
			ep.push_back(CONV_CYC - ACQ_CYC);
		end
	endtask

	// Bounded wait on the go bit level or on a count of taken results
	task automatic wt(input bit by_take, input int tgt, input int lim);
		int i;
		for (i = 0; i < lim && (by_take ? n_take < tgt : conversion_go_bit !== tgt[0]); i++) begin
			@(posedge clk);
			if (by_take) begin
				res_ready <= rnd() > 16'h6000;
			end
		end
		if (by_take ? n_take < tgt : conversion_go_bit !== tgt[0]) begin
			n_fail++;
			test_done();
		end
	endtask

	// Monitor: converter pulses between sample edges, front-end snapshots, taken results
	always @(posedge clk) begin
		logic [15:0] e;
		// Only a go write that the rules accept starts a new run
		if (go_write === 1'b1 && stop_mode === 1'b0 && busy === 1'b0) begin
			np = 0;
			n_run = 0;
		end
		if (converter_clock === 1'b1) np++;
		if (rstn === 1'b1 && (sample !== sp || (gp === 1'b1 && conversion_go_bit === 1'b0))) begin
			qp.push_back(np);
			np = 0;
		end
		if (sample === 1'b1 && sp === 1'b0)
			qf.push_back({diode_bias_on, diode_bias, mux_sel, diff_sel, ref_internal, fs_low, gain_trim});
		if (res_valid === 1'b1 && res_ready === 1'b1) begin
			e = eq.pop_front();
			chk(samples_ready_flag, n_run >= ready_count);
			chk({res_chan, res_data}, e);
			m[n_take % NUM_BUF] = e[12:0];
			n_take++;
			n_run++;
		end
		// Edge history stays at idle levels while in reset, so no false edge follows it
		sp = (rstn === 1'b1) ? sample : 1'b0;
		gp = (rstn === 1'b1) ? conversion_go_bit : 1'b0;
	end

	initial begin
		int i, sz;
		logic [7:0] c0, c1, c2;
		logic [15:0] r;
		@(posedge clk);
		@(negedge clk) chk({conversion_go_bit, samples_ready_flag, busy, powered_down, res_valid}, 5'h02);
		@(posedge clk);
		rstn <= 1'b1;
		r = rnd();
		c0 = 8'h20 | 8'(r[3:0] % 4'd6);
		c1 = 8'h58 | 8'(r[7:4] % 4'd6);
		c2 = 8'hC0 | 8'(r[11:8] % 4'd6);
		acq_ext <= {5'h00, r[14:12]};
		r = rnd();
		low_range_gain_trim <= r[7:0];
		high_range_gain_trim <= r[15:8];
		fs_high <= 1'b1;
		slot_cfg <= {40'h0, c2, c1, c0};
		@(posedge clk);
		ep.push_back(START_WAIT);
		add_slot(c0);
		add_slot(c1);
		add_slot(c2);
		go_write <= 1'b1;
		@(posedge clk) go_write <= 1'b0;
		@(negedge clk) chk({conversion_go_bit, busy, powered_down}, 3'h6);
		wt(1'b0, 0, 8000);
		@(negedge clk) chk({eq.size() == 0, samples_ready_flag, powered_down}, 3'h7);
		chk(qp.size(), ep.size());
		for (i = 0; i < ep.size(); i++) chk(qp[i], ep[i]);
		chk(qf.size(), ef.size());
		for (i = 0; i < ef.size(); i++) chk(qf[i], ef[i]);
		// Continuous loop over the die input and a left-aligned input
		c0 = 8'h07;
		c1 = 8'h10 | 8'(rnd() % 16'd6);
		@(posedge clk);
		slot_cfg <= {48'h0, c1, c0};
		seq_len <= 4'h2;
		cont_mode <= 1'b1;
		fs_high <= 1'b0;
		ready_count <= 5'h04;
		res_ready <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 15; i++) begin
			add_slot(c0);
			add_slot(c1);
		end
		go_write <= 1'b1;
		@(posedge clk) go_write <= 1'b0;
		@(negedge clk) chk({samples_ready_flag, busy}, 2'h1);
		// Receiver stalls long enough to fill the buffer and hold the sequencer
		repeat (2200) @(posedge clk);
		sz = qf.size();
		repeat (700) @(posedge clk);
		@(negedge clk) chk(qf.size(), sz);
		chk(res_valid, 1'b1);
		wt(1'b1, 23, 40000);
		@(posedge clk);
		stop_mode <= 1'b1;
		res_ready <= 1'b1;
		@(posedge clk) go_write <= 1'b1;
		@(negedge clk) chk({conversion_go_bit, busy, powered_down}, 3'h1);
		@(posedge clk) go_write <= 1'b0;
		@(negedge clk) chk(conversion_go_bit, 1'b0);
		repeat (5) @(posedge clk);
		flag_clear <= 1'b1;
		@(posedge clk) flag_clear <= 1'b0;
		@(negedge clk) chk(samples_ready_flag, 1'b0);
		chk(wr_ptr, n_take % NUM_BUF);
		for (i = 0; i < NUM_BUF; i++) begin
			@(posedge clk) rd_idx <= 4'(i);
			@(posedge clk);
			@(negedge clk) chk(rd_data, m[i]);
		end
		@(posedge clk) stop_mode <= 1'b0;
		repeat (30) @(posedge clk);
		@(negedge clk) chk({conversion_go_bit, powered_down}, 2'h1);
		@(posedge clk) go_write <= 1'b1;
		@(posedge clk) go_write <= 1'b0;
		@(negedge clk) chk({conversion_go_bit, busy}, 2'h3);
		test_done();
	end
endmodule
`default_nettype wire
